// ---- inc/dsst_defines.vh ----
// constants for the demodulator sample stream trigger block
`ifndef DSST_DEFINES_VH
`define DSST_DEFINES_VH

// register byte offsets
`define DSST_ADDR_ENABLE 8'h00
`define DSST_ADDR_LOCK 8'h04
`define DSST_ADDR_STATUS 8'h08
`define DSST_ADDR_CFG0 8'h10
`define DSST_CFG_STRIDE 4

// per-demodulator configuration word layout
`define DSST_PERIOD_MSB 25
`define DSST_PERIOD_LSB 0
`define DSST_SRC_MSB 28
`define DSST_SRC_LSB 26
`define DSST_MODE_MSB 31
`define DSST_MODE_LSB 29
`define DSST_LOCK_BIT 0

// trigger sources
`define DSST_SRC_CONT 3'h0
`define DSST_SRC_IN3 3'h1
`define DSST_SRC_IN4 3'h2
`define DSST_SRC_OR34 3'h3
`define DSST_SRC_WG1 3'h4
`define DSST_SRC_WG2 3'h5
`define DSST_SRC_WG3 3'h6
`define DSST_SRC_WG4 3'h7

// trigger modes
`define DSST_MODE_RISE 3'h0
`define DSST_MODE_FALL 3'h1
`define DSST_MODE_BOTH 3'h2
`define DSST_MODE_HIGH 3'h3
`define DSST_MODE_LOW 3'h4

// clock and rate limits in samples_per_second; lowest rate is 21/50 = 0.42
`define DSST_CLK_HZ 25000000
`define DSST_RATE_MAX_SPS 14000000
`define DSST_RATE_MIN_NUM 21
`define DSST_RATE_MIN_DEN 50

// reset values and number of demodulators
`define DSST_PERIOD_DEF 26'h0003a98
`define DSST_NUM_DEMOD 8

// cycles after reset before edge detection is trusted
`define DSST_EDGE_SETTLE 2'h3

`endif

// ---- design/dsst_stream.v ----
// demodulator sample gating: enable, rate divider, trigger source and mode
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dsst_defines.vh"

module dsst_stream #(
  parameter integer NUM_DEMOD = `DSST_NUM_DEMOD,
  parameter integer PERIOD_MIN = (`DSST_CLK_HZ + `DSST_RATE_MAX_SPS - 1) / `DSST_RATE_MAX_SPS,
  parameter integer PERIOD_MAX = `DSST_CLK_HZ * `DSST_RATE_MIN_DEN / `DSST_RATE_MIN_NUM
) (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [31:0] bus_rdata,
  input wire trig_in3,
  input wire trig_in4,
  input wire [3:0] wavegen_trigger_output,
  output reg [NUM_DEMOD-1:0] sample_take
);

  localparam [25:0] PMIN = PERIOD_MIN[25:0];
  localparam [25:0] PMAX = PERIOD_MAX[25:0];
  localparam integer CFG_END_I = `DSST_ADDR_CFG0 + NUM_DEMOD * `DSST_CFG_STRIDE;
  localparam [7:0] CFG_END = CFG_END_I[7:0];
  localparam [7:0] CFG0 = `DSST_ADDR_CFG0;

  // rate is clock over period, so an integer period is the nearest rate
  // clamp a requested period into the supported range
  function [25:0] clamp_period;
    input [25:0] req;
    begin
      if (req < PMIN) begin
        clamp_period = PMIN;
      end else if (req > PMAX) begin
        clamp_period = PMAX;
      end else begin
        clamp_period = req;
      end
    end
  endfunction

  reg [NUM_DEMOD-1:0] enable_reg;
  reg lock_reg;
  reg trig3_meta_reg;
  reg trig3_sync_reg;
  reg trig4_meta_reg;
  reg trig4_sync_reg;
  reg [7:0] prev_vec_reg;
  reg [31:0] rdata_next;

  wire [7:0] src_vec;
  wire trig_or;
  wire lock_rise;
  wire cfg_region;
  wire cfg_any_wr;
  wire [7:0] cfg_off;
  wire [5:0] cfg_idx;
  wire [25:0] wr_period;
  wire [32*NUM_DEMOD-1:0] cfg_flat;
  wire [NUM_DEMOD-1:0] active_vec;
  wire [NUM_DEMOD-1:0] take_next;
  wire [25:0] lead_period;
  wire settled;
  reg [1:0] settle_reg;

  // external trigger pins pass two flip-flops first
  always @(posedge core_clk) begin
    if (!rst_n) begin
      trig3_meta_reg <= 1'b0;
      trig3_sync_reg <= 1'b0;
      trig4_meta_reg <= 1'b0;
      trig4_sync_reg <= 1'b0;
    end else begin
      trig3_meta_reg <= trig_in3;
      trig3_sync_reg <= trig3_meta_reg;
      trig4_meta_reg <= trig_in4;
      trig4_sync_reg <= trig4_meta_reg;
    end
  end

  assign trig_or = trig3_sync_reg | trig4_sync_reg;

  // index by source code; entry 0 stands for continuous
  assign src_vec = {wavegen_trigger_output, trig_or, trig4_sync_reg, trig3_sync_reg, 1'b1};

  // previous source levels for edge detection
  always @(posedge core_clk) begin
    if (!rst_n) begin
      prev_vec_reg <= 8'h00;
    end else begin
      prev_vec_reg <= src_vec;
    end
  end

  // edge detection waits until synchronisers and previous levels hold real samples,
  // so a pin already high when reset ends gives no false edge
  always @(posedge core_clk) begin
    if (!rst_n) begin
      settle_reg <= 2'h0;
    end else if (!settled) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  assign settled = (settle_reg == `DSST_EDGE_SETTLE);

  // global registers
  always @(posedge core_clk) begin
    if (!rst_n) begin
      enable_reg <= {NUM_DEMOD{1'b0}};
      lock_reg <= 1'b0;
    end else if (bus_wr) begin
      if (bus_addr == `DSST_ADDR_ENABLE) begin
        enable_reg <= bus_wdata[NUM_DEMOD-1:0];
      end
      if (bus_addr == `DSST_ADDR_LOCK) begin
        lock_reg <= bus_wdata[`DSST_LOCK_BIT];
      end
    end
  end

  // a lock write from 0 to 1 copies the first period to every demodulator
  assign lock_rise = bus_wr && (bus_addr == `DSST_ADDR_LOCK) && bus_wdata[`DSST_LOCK_BIT] && !lock_reg;
  // configuration words sit on a word stride from the first one
  assign cfg_region = (bus_addr >= CFG0) && (bus_addr < CFG_END) && (bus_addr[1:0] == 2'h0);
  assign cfg_any_wr = bus_wr && cfg_region;
  assign cfg_off = bus_addr - CFG0;
  assign cfg_idx = cfg_off[7:2];
  assign wr_period = clamp_period(bus_wdata[`DSST_PERIOD_MSB:`DSST_PERIOD_LSB]);
  // the first demodulator's period is the source of a lock copy
  assign lead_period = cfg_flat[`DSST_PERIOD_MSB:`DSST_PERIOD_LSB];


  genvar gi;
  generate
    for (gi = 0; gi < NUM_DEMOD; gi = gi + 1) begin : g_demod
      localparam integer MY_ADDR_I = `DSST_ADDR_CFG0 + gi * `DSST_CFG_STRIDE;
      localparam [7:0] MY_ADDR = MY_ADDR_I[7:0];

      reg [25:0] period_reg;
      reg [2:0] src_reg;
      reg [2:0] mode_reg;
      reg [25:0] cnt_reg;
      reg restart_reg;

      wire own_wr;
      wire period_wr;
      wire lvl;
      wire prv;
      wire rise;
      wire fall;
      reg edge_sel;
      reg edge_fire;
      reg gate;
      wire rate_fire;

      assign own_wr = bus_wr && (bus_addr == MY_ADDR);
      assign period_wr = own_wr || (cfg_any_wr && lock_reg);

      // configuration word of this demodulator
      always @(posedge core_clk) begin
        if (!rst_n) begin
          period_reg <= `DSST_PERIOD_DEF;
          src_reg <= `DSST_SRC_CONT;
          mode_reg <= `DSST_MODE_RISE;
        end else begin
          if (lock_rise) begin
            period_reg <= lead_period;
          end else if (period_wr) begin
            period_reg <= wr_period;
          end
          if (own_wr) begin
            src_reg <= bus_wdata[`DSST_SRC_MSB:`DSST_SRC_LSB];
            mode_reg <= bus_wdata[`DSST_MODE_MSB:`DSST_MODE_LSB];
          end
        end
      end

      assign lvl = src_vec[src_reg];
      assign prv = prev_vec_reg[src_reg];
      assign rise = settled & lvl & ~prv;
      assign fall = settled & ~lvl & prv;

      // mode decode; continuous ignores the mode, reserved modes fire nothing
      always @* begin
        edge_sel = 1'b0;
        edge_fire = 1'b0;
        gate = 1'b0;
        if (src_reg == `DSST_SRC_CONT) begin
          gate = 1'b1;
        end else begin
          case (mode_reg)
            `DSST_MODE_RISE: begin
              edge_sel = 1'b1;
              edge_fire = rise;
            end
            `DSST_MODE_FALL: begin
              edge_sel = 1'b1;
              edge_fire = fall;
            end
            `DSST_MODE_BOTH: begin
              edge_sel = 1'b1;
              edge_fire = rise | fall;
            end
            `DSST_MODE_HIGH: begin
              gate = lvl;
            end
            `DSST_MODE_LOW: begin
              gate = ~lvl;
            end
            default: begin
              gate = 1'b0;
            end
          endcase
        end
      end

      // restart the divider after any change to rate or source
      always @(posedge core_clk) begin
        if (!rst_n) begin
          restart_reg <= 1'b1;
        end else begin
          restart_reg <= period_wr || own_wr || lock_rise;
        end
      end

      // rate divider, held at reload while gated off or disabled
      always @(posedge core_clk) begin
        if (!rst_n) begin
          cnt_reg <= `DSST_PERIOD_DEF - 26'h0000001;
        end else if (restart_reg || !gate || !enable_reg[gi] || edge_sel) begin
          cnt_reg <= period_reg - 26'h0000001;
        end else if (cnt_reg == 26'h0000000) begin
          cnt_reg <= period_reg - 26'h0000001;
        end else begin
          cnt_reg <= cnt_reg - 26'h0000001;
        end
      end

      assign rate_fire = !edge_sel && gate && !restart_reg && (cnt_reg == 26'h0000000);
      // edge modes ignore the rate and give one sample per edge
      assign take_next[gi] = enable_reg[gi] && ((edge_sel && edge_fire) || rate_fire);
      assign active_vec[gi] = enable_reg[gi] && (edge_sel || gate);
      assign cfg_flat[32*gi +: 32] = {mode_reg, src_reg, period_reg};
    end
  endgenerate

  // sample strobes feed only the host stream, not the auxiliary outputs
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sample_take <= {NUM_DEMOD{1'b0}};
    end else begin
      sample_take <= take_next;
    end
  end

  // read multiplexer, unmapped offsets read zero
  always @* begin
    rdata_next = 32'h00000000;
    if (bus_addr == `DSST_ADDR_ENABLE) begin
      rdata_next[NUM_DEMOD-1:0] = enable_reg;
    end else if (bus_addr == `DSST_ADDR_LOCK) begin
      rdata_next[`DSST_LOCK_BIT] = lock_reg;
    end else if (bus_addr == `DSST_ADDR_STATUS) begin
      rdata_next[NUM_DEMOD-1:0] = active_vec;
    end else if (cfg_region) begin
      rdata_next = cfg_flat[cfg_idx*32 +: 32];
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always @(posedge core_clk) begin
    if (!rst_n) begin
      bus_rdata <= 32'h00000000;
    end else if (bus_rd) begin
      bus_rdata <= rdata_next;
    end else begin
      bus_rdata <= 32'h00000000;
    end
  end

endmodule // dsst_stream
`default_nettype wire

// ---- tb/dsst_stream_checker.sv ----
// assertions on the ports of the sample stream block
`timescale 1ns/1ps
`default_nettype none
module dsst_stream_checker #(parameter integer NUM_DEMOD = 8) (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [31:0] bus_rdata,
  input wire trig_in3,
  input wire trig_in4,
  input wire [3:0] wavegen_trigger_output,
  input wire [NUM_DEMOD-1:0] sample_take
);
  logic [NUM_DEMOD-1:0] en_q;
  logic [NUM_DEMOD-1:0] en_p;
  logic [31:0] cfg;
  logic [2:0] age;
  wire [3:0] w = wavegen_trigger_output;
  // q: demod 0 enabled and no bus write for seven cycles
  wire q = age == 3'h7 && en_q[0];
  always @(posedge core_clk) begin
    if (!rst_n) begin
      en_q <= '0;
      en_p <= '0;
      cfg <= '0;
      age <= 3'h0;
    end else begin
      en_p <= en_q;
      if (bus_wr && bus_addr == 8'h00) en_q <= bus_wdata[NUM_DEMOD-1:0];
      if (bus_wr && bus_addr == 8'h10) cfg <= bus_wdata;
      age <= bus_wr ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_OFF_QUIET: assert property ((sample_take & ~(en_q | en_p)) == '0) else $error("pulse while off");
  AST_FLOOR: assert property (bus_wr && bus_addr == 8'h10 && bus_wdata[25:0] < 26'h2 ##1 bus_rd && bus_addr == 8'h10
    |=> bus_rdata[25:0] == 26'h2) else $error("period floor");
  AST_SPACING: assert property (q && sample_take[0] && cfg[28:0] == 29'h4 |=> !sample_take[0] [*3])
    else $error("rate spacing");
  AST_WG1_RISE: assert property (q && cfg[31:26] == 6'h04 && $rose(w[0]) |-> ##1 sample_take[0])
    else $error("wavegen rise");
  AST_IN3_FALL: assert property (q && cfg[31:26] == 6'h09 && $fell(trig_in3) |-> ##3 sample_take[0])
    else $error("input fall");
  AST_OR_RISE: assert property (q && cfg[31:26] == 6'h03 && $rose(trig_in3 | trig_in4) |-> ##3 sample_take[0])
    else $error("or rise");
  AST_WG4_BOTH: assert property (q && cfg[31:26] == 6'h17 && $changed(w[3]) |-> ##1 sample_take[0])
    else $error("wavegen both");
  AST_EDGE_ONLY: assert property (q && cfg[28] && cfg[31:29] <= 3'h2 && sample_take[0] |-> $past(w) != $past(w, 2))
    else $error("edge without event");
endmodule // dsst_stream_checker
bind dsst_stream dsst_stream_checker #(.NUM_DEMOD(NUM_DEMOD)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .trig_in3(trig_in3), .trig_in4(trig_in4), .wavegen_trigger_output(wavegen_trigger_output),
  .sample_take(sample_take));
`default_nettype wire

// ---- tb/dsst_host.sv ----
// host model counting streamed samples of demodulator 0
`timescale 1ns/1ps
`default_nettype none
module dsst_host #(parameter integer NUM_DEMOD = 8) (
  input wire core_clk,
  input wire [NUM_DEMOD-1:0] sample_take,
  output logic [15:0] cnt
);
  initial cnt = 16'h0;
  // any rate is accepted, the bandwidth ratio is a host choice
  always @(posedge core_clk) cnt <= cnt + {15'h0, sample_take[0]};
endmodule // dsst_host
`default_nettype wire

// ---- tb/dsst_stream_bench.sv ----
// self-checking bench for the sample stream block
`timescale 1ns/1ps
`default_nettype none
`include "dsst_defines.vh"
module dsst_stream_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] a_q = 8'h00;
  logic [31:0] d_q = 32'h0;
  logic wr_q = 1'b0;
  logic rd_q = 1'b0;
  logic t3 = 1'b0;
  logic t4 = 1'b0;
  logic [3:0] wg = 4'h0;
  wire [31:0] rdata;
  wire [7:0] take;
  wire [15:0] cnt;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [15:0] b;
  always #20 core_clk = ~core_clk;
  dsst_stream dut (.core_clk(core_clk), .rst_n(rst_n), .bus_addr(a_q), .bus_wdata(d_q), .bus_wr(wr_q),
    .bus_rd(rd_q), .bus_rdata(rdata), .trig_in3(t3), .trig_in4(t4), .wavegen_trigger_output(wg), .sample_take(take));
  dsst_host host (.core_clk(core_clk), .sample_take(take), .cnt(cnt));
  task automatic give_verdict;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    a_q <= a;
    d_q <= d;
    rd_q <= 1'b0;
    wr_q <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    a_q <= a;
    wr_q <= 1'b0;
    rd_q <= 1'b1;
    @(posedge core_clk);
    rd_q <= 1'b0;
    #1;
    chk(n, rdata, e);
    @(posedge core_clk);
  endtask
  task automatic idle(input int c);
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    repeat (c) @(posedge core_clk);
  endtask
  task automatic setp(input int s, input logic v);
    if (s == 1) t3 <= v;
    else if (s < 4) t4 <= v;
    else wg[s-4] <= v;
  endtask
  task automatic count(input int c, input string n, input logic [15:0] e);
    idle(8);
    b = cnt;
    idle(c);
    chk(n, {16'h0, cnt - b}, {16'h0, e});
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      give_verdict;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(`DSST_ADDR_ENABLE, 32'h0, "enable");
    rd(`DSST_ADDR_CFG0, {6'h0, `DSST_PERIOD_DEF}, "cfg0");
    rd(8'h0c, 32'h0, "unmapped");
    wr(`DSST_ADDR_CFG0, 32'h0);
    rd(`DSST_ADDR_CFG0, 32'h2, "floor");
    wr(`DSST_ADDR_CFG0, 32'h03ffffff);
    rd(`DSST_ADDR_CFG0, 32'h038c42e1, "ceiling");
    wr(8'h14, 32'h6);
    wr(8'h10, 32'h4);
    wr(`DSST_ADDR_LOCK, 32'h1);
    rd(8'h14, 32'h4, "lock copy");
    wr(8'h18, 32'h8);
    rd(8'h10, 32'h8, "lock fan");
    wr(`DSST_ADDR_LOCK, 32'h0);
    wr(8'h14, 32'ha);
    rd(8'h10, 32'h8, "unlock");
    wr(8'h10, 32'h4);
    wr(`DSST_ADDR_ENABLE, 32'h1);
    rd(`DSST_ADDR_STATUS, 32'h1, "status open");
    count(40, "cont rate", 16'd10);
    wr(`DSST_ADDR_ENABLE, 32'h0);
    count(40, "off", 16'd0);
    wr(`DSST_ADDR_ENABLE, 32'h1);
    for (int s = 1; s < 8; s++) begin
      for (int m = 0; m < 3; m++) begin
        wr(8'h10, {m[2:0], s[2:0], 26'h4});
        idle(8);
        b = cnt;
        setp(s, 1'b1);
        idle(8);
        setp(s, 1'b0);
        idle(8);
        chk("edge", {16'h0, cnt - b}, (m == 2) ? 32'h2 : 32'h1);
      end
    end
    wr(8'h10, {`DSST_MODE_HIGH, `DSST_SRC_IN4, 26'h4});
    count(40, "level low", 16'd0);
    rd(`DSST_ADDR_STATUS, 32'h0, "status closed");
    setp(2, 1'b1);
    idle(4);
    b = cnt;
    idle(40);
    chk("level high", {16'h0, cnt - b}, 32'd10);
    wr(8'h10, {`DSST_MODE_LOW, `DSST_SRC_IN4, 26'h4});
    count(20, "level inv", 16'd0);
    setp(2, 1'b0);
    count(40, "level low on", 16'd10);
    give_verdict;
  end
endmodule // dsst_stream_bench
`default_nettype wire
